/* design/ncc_pkg.sv */
package ncc_pkg;

  // Register map, byte addresses on a 32-bit Wishbone data path
  localparam int unsigned NCC_ADR_W = 4;
  localparam logic [3:0] NCC_CMD_OFS = 4'h0;
  localparam logic [3:0] NCC_TIMER_OFS = 4'h4;

  // Command register bit positions
  localparam int unsigned NCC_B_STOP_SENDING = 0;
  localparam int unsigned NCC_B_SEND_FRAMES = 1;
  localparam int unsigned NCC_B_RECEIVE_OFF = 2;
  localparam int unsigned NCC_B_RECEIVE_ON = 3;
  localparam int unsigned NCC_B_TIMER_HALT = 4;
  localparam int unsigned NCC_B_TIMER_RUN = 5;
  localparam int unsigned NCC_B_SOFT_RESET = 7;
  localparam int unsigned NCC_B_FETCH_DESC = 8;
  localparam int unsigned NCC_B_LOAD_FILTER = 9;

  // Reset values and masks of the command register
  localparam logic [15:0] NCC_CMD_HW_RESET = 16'h0094;
  localparam logic [15:0] NCC_CMD_SW_SET = 16'h0084;
  localparam logic [15:0] NCC_CMD_SW_CLR = 16'h0303;
  localparam logic [15:0] NCC_CMD_IMPL = 16'h03bf;
  localparam logic [15:0] NCC_CMD_PLAIN = 16'h0303;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [NCC_ADR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } ncc_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } ncc_wb_rsp_t;

  // Status returned by the engines that the commands drive
  typedef struct packed {
    logic filterDone;
    logic fetchDone;
    logic eolSeen;
    logic txAbort;
    logic frameDone;
    logic rxFrameBusy;
  } ncc_eng_in_t;

  typedef struct packed {
    logic loadFilterReq;
    logic fetchDescReq;
    logic engineReset;
    logic crcEnable;
    logic tallyRun;
    logic sendActive;
    logic haltReq;
    logic rxBuffering;
    logic timerRun;
  } ncc_eng_out_t;

  typedef enum logic [2:0] {
    NCC_TX_IDLE = 3'b001,
    NCC_TX_RUN = 3'b010,
    NCC_TX_HALT = 3'b100
  } ncc_tx_st_t;

  typedef enum logic [1:0] {
    NCC_BUS_IDLE = 2'b01,
    NCC_BUS_ACK = 2'b10
  } ncc_bus_st_t;

  typedef struct packed {
    logic [15:0] cmd;
    ncc_tx_st_t txState;
    logic rxLastOn;
    ncc_eng_out_t eng;
  } ncc_main_st_t;

  localparam ncc_eng_out_t NCC_ENG_RESET = '{engineReset: 1'b1, default: 1'b0};
  localparam ncc_main_st_t NCC_MAIN_RESET = '{cmd: NCC_CMD_HW_RESET, txState: NCC_TX_IDLE,
                                              rxLastOn: 1'b0, eng: NCC_ENG_RESET};

  // Byte lanes 0 and 1 cover the 16 register bits
  function automatic logic [15:0] ncc_byte_mask(input logic [3:0] sel);
    ncc_byte_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction : ncc_byte_mask

endpackage : ncc_pkg

/* design/ncc_wb_slave.sv */
`timescale 1ns/1ps
module ncc_wb_slave (
  input logic core_clk,
  input logic arst_n,
  input ncc_pkg::ncc_wb_req_t wbReq,
  input logic [31:0] rdData,
  output ncc_pkg::ncc_wb_rsp_t wbRsp,
  output logic wrEn
);
  import ncc_pkg::*;

  typedef struct packed {
    ncc_bus_st_t state;
    ncc_wb_rsp_t rsp;
  } ncc_slv_st_t;

  ncc_slv_st_t q;
  ncc_slv_st_t d;

  // One wait state: ack rises one edge after the request is seen
  always_comb begin
    d = q;
    case (q.state)
      NCC_BUS_IDLE: begin
        if (wbReq.cyc && wbReq.stb) begin
          d.state = NCC_BUS_ACK;
          d.rsp.ack = 1'b1;
          d.rsp.dat = wbReq.we ? 32'h0000_0000 : rdData;
        end
      end
      NCC_BUS_ACK: begin
        d.state = NCC_BUS_IDLE;
        d.rsp.ack = 1'b0;
        d.rsp.dat = 32'h0000_0000;
      end
      default: begin
        d.state = NCC_BUS_IDLE;
        d.rsp.ack = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{state: NCC_BUS_IDLE, rsp: '0};
    end else begin
      q <= d;
    end
  end

  // Write lands on the same edge at which the master samples ack
  assign wrEn = q.rsp.ack && wbReq.cyc && wbReq.stb && wbReq.we;
  assign wbRsp = q.rsp;

endmodule : ncc_wb_slave

/* design/ncc_watchdog.sv */
`timescale 1ns/1ps
module ncc_watchdog (
  input logic core_clk,
  input logic arst_n,
  input logic load,
  input logic [31:0] loadValue,
  input logic run,
  input logic irqEnable,
  output logic [31:0] count,
  output logic irq
);
  import ncc_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic irq;
  } ncc_wdt_st_t;

  ncc_wdt_st_t q;
  ncc_wdt_st_t d;

  // Load wins over counting; the counter wraps after zero like a free timer
  always_comb begin
    d = q;
    d.irq = 1'b0;
    if (load) begin
      d.count = loadValue;
    end else if (run) begin
      d.count = q.count - 32'h0000_0001;
      d.irq = irqEnable && (q.count == 32'h0000_0001);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.count;
  assign irq = q.irq;

  a_count_needs_run: assert property (@(posedge core_clk) disable iff (!arst_n)
    !load && !run |=> count == $past(count)) else $error("timer moved while halted");
  a_irq_at_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    run && !load && irqEnable && count == 32'h0000_0001 |=> irq && count == 32'h0000_0000)
    else $error("no interrupt at zero count");
  c_timer_fires: cover property (@(posedge core_clk) disable iff (!arst_n) irq);

endmodule : ncc_watchdog

/* design/ncc_command_reg.sv */
`timescale 1ns/1ps
// Overview of operation
// - Bits 9, 8, 1 and 0 self-clear when their operation completes; soft reset stays set.
// - Writing zero to any command bit except soft reset has no effect.
// - The watchdog counts down only after the run bit is set.
// - Reaching zero raises the timer interrupt when its mask enables it.
// - Hardware reset sets bits 7, 4 and 2 and clears all others.
// - Soft reset clears bits 9, 8, 1, 0, sets 7 and 2, keeps the rest.
// - Bit 9 loads the address filter table from its descriptor.
// - Bit 8 fetches the next receive resource descriptor.
// - Soft reset resets state machines, disables CRC, halts tally counters.
// - Device stays idle while soft reset is one, resumes when cleared.
// - Bit 5 starts or resumes the timer and clears halt; halting clears it.
// - Bit 4 halts the timer and clears run; it powers up set.
// - Setting run and halt together stops the timer.
// - Send clears on end of list, halt taking effect, or transmit abort.
// - Stop sending ends sending after the current frame, then send clears.
// - Receive on starts buffering, clears receive off once the line is idle.
// - Receive off stops buffering at once, clears receive on once the line is idle.
module ncc_command_reg (
  input logic core_clk,
  input logic arst_n,
  input ncc_pkg::ncc_wb_req_t wbReq,
  output ncc_pkg::ncc_wb_rsp_t wbRsp,
  input ncc_pkg::ncc_eng_in_t engIn,
  output ncc_pkg::ncc_eng_out_t engOut,
  input logic timerLoad,
  input logic [31:0] timerLoadValue,
  input logic timerIrqEnable,
  output logic [31:0] timerCount,
  output logic timerIrq
);
  import ncc_pkg::*;

  ncc_main_st_t q;
  ncc_main_st_t d;
  logic wrEn;
  logic [31:0] rdData;
  logic [15:0] wrMask;
  logic [15:0] wrSet;
  logic wrCmd;
  logic swRstWr;
  logic opWr;
  logic [15:0] cmd;
  logic running;

  // Decode of the write that lands this cycle
  assign wrMask = ncc_byte_mask(wbReq.sel);
  assign wrSet = wbReq.dat[15:0] & wrMask & NCC_CMD_IMPL;
  assign wrCmd = wrEn && (wbReq.adr == NCC_CMD_OFS);
  assign swRstWr = wrCmd && !q.cmd[NCC_B_SOFT_RESET] && wrSet[NCC_B_SOFT_RESET];
  assign opWr = wrCmd && !q.cmd[NCC_B_SOFT_RESET] && !swRstWr;
  assign running = !q.cmd[NCC_B_SOFT_RESET];

  // Bus slave with one registered wait state
  ncc_wb_slave u_slave (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wbReq(wbReq),
    .rdData(rdData),
    .wbRsp(wbRsp),
    .wrEn(wrEn)
  );

  // Watchdog counts from the registered run level
  ncc_watchdog u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(timerLoad),
    .loadValue(timerLoadValue),
    .run(q.eng.timerRun),
    .irqEnable(timerIrqEnable),
    .count(timerCount),
    .irq(timerIrq)
  );

  // Read mux; unmapped words read as zero
  always_comb begin
    rdData = 32'h0000_0000;
    if (wbReq.adr == NCC_CMD_OFS) begin
      rdData = {16'h0000, q.cmd};
    end else if (wbReq.adr == NCC_TIMER_OFS) begin
      rdData = timerCount;
    end
  end

  // Completions are applied first so that a write in the same cycle wins
  always_comb begin
    d = q;
    cmd = q.cmd;
    if (running) begin
      if (engIn.filterDone) begin
        cmd[NCC_B_LOAD_FILTER] = 1'b0;
      end
      if (engIn.fetchDone) begin
        cmd[NCC_B_FETCH_DESC] = 1'b0;
      end
      // Transmit command tracking
      case (q.txState)
        NCC_TX_IDLE: begin
          if (q.cmd[NCC_B_SEND_FRAMES]) begin
            d.txState = q.cmd[NCC_B_STOP_SENDING] ? NCC_TX_HALT : NCC_TX_RUN;
          end else if (q.cmd[NCC_B_STOP_SENDING]) begin
            cmd[NCC_B_STOP_SENDING] = 1'b0; // Nothing to halt, done at once
          end
        end
        NCC_TX_RUN: begin
          if (engIn.eolSeen || engIn.txAbort) begin
            cmd[NCC_B_SEND_FRAMES] = 1'b0;
            cmd[NCC_B_STOP_SENDING] = 1'b0;
            d.txState = NCC_TX_IDLE;
          end else if (q.cmd[NCC_B_STOP_SENDING]) begin
            d.txState = NCC_TX_HALT;
          end
        end
        NCC_TX_HALT: begin
          if (engIn.frameDone || engIn.eolSeen || engIn.txAbort) begin
            cmd[NCC_B_SEND_FRAMES] = 1'b0;
            cmd[NCC_B_STOP_SENDING] = 1'b0;
            d.txState = NCC_TX_IDLE;
          end
        end
        default: begin
          d.txState = NCC_TX_IDLE;
        end
      endcase
      // Both receive bits stay set until the line is idle, then the later one wins
      if (q.cmd[NCC_B_RECEIVE_ON] && q.cmd[NCC_B_RECEIVE_OFF] && !engIn.rxFrameBusy) begin
        if (q.rxLastOn) begin
          cmd[NCC_B_RECEIVE_OFF] = 1'b0;
        end else begin
          cmd[NCC_B_RECEIVE_ON] = 1'b0;
        end
      end
    end
    // Software writes
    if (wrCmd && q.cmd[NCC_B_SOFT_RESET]) begin
      // Only the reset bit itself acts while held in reset
      if (wrMask[NCC_B_SOFT_RESET]) begin
        cmd[NCC_B_SOFT_RESET] = wbReq.dat[NCC_B_SOFT_RESET];
      end
    end else if (swRstWr) begin
      cmd = (cmd & ~NCC_CMD_SW_CLR) | NCC_CMD_SW_SET;
      d.txState = NCC_TX_IDLE;
    end else if (opWr) begin
      cmd = cmd | (wrSet & NCC_CMD_PLAIN); // Zeros leave bits alone
      if (wrSet[NCC_B_TIMER_HALT]) begin
        cmd[NCC_B_TIMER_HALT] = 1'b1; // Halt beats run
        cmd[NCC_B_TIMER_RUN] = 1'b0;
      end else if (wrSet[NCC_B_TIMER_RUN]) begin
        cmd[NCC_B_TIMER_RUN] = 1'b1;
        cmd[NCC_B_TIMER_HALT] = 1'b0;
      end
      if (wrSet[NCC_B_RECEIVE_ON]) begin
        cmd[NCC_B_RECEIVE_ON] = 1'b1;
        d.rxLastOn = 1'b1;
        if (!engIn.rxFrameBusy) begin
          cmd[NCC_B_RECEIVE_OFF] = 1'b0;
        end
      end
      // Receive off written last so it beats receive on in one write
      if (wrSet[NCC_B_RECEIVE_OFF]) begin
        cmd[NCC_B_RECEIVE_OFF] = 1'b1;
        d.rxLastOn = 1'b0;
        if (!engIn.rxFrameBusy) begin
          cmd[NCC_B_RECEIVE_ON] = 1'b0;
        end
      end
    end
    d.cmd = cmd;
    // Engine controls are registered from the next command value
    d.eng.engineReset = cmd[NCC_B_SOFT_RESET];
    d.eng.crcEnable = !cmd[NCC_B_SOFT_RESET];
    d.eng.tallyRun = !cmd[NCC_B_SOFT_RESET]; // Tallies halt but keep contents
    d.eng.loadFilterReq = cmd[NCC_B_LOAD_FILTER] && !cmd[NCC_B_SOFT_RESET];
    d.eng.fetchDescReq = cmd[NCC_B_FETCH_DESC] && !cmd[NCC_B_SOFT_RESET];
    d.eng.sendActive = cmd[NCC_B_SEND_FRAMES] && !cmd[NCC_B_SOFT_RESET];
    d.eng.haltReq = cmd[NCC_B_STOP_SENDING] && !cmd[NCC_B_SOFT_RESET];
    d.eng.rxBuffering = cmd[NCC_B_RECEIVE_ON] && !cmd[NCC_B_RECEIVE_OFF]
                        && !cmd[NCC_B_SOFT_RESET];
    d.eng.timerRun = cmd[NCC_B_TIMER_RUN] && !cmd[NCC_B_SOFT_RESET];
  end

  // Hardware reset loads bits 7, 4 and 2
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= NCC_MAIN_RESET;
    end else begin
      q <= d;
    end
  end

  assign engOut = q.eng;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_filter_done_clears: assert property (running && q.cmd[NCC_B_LOAD_FILTER]
    && engIn.filterDone && !(opWr && wrSet[NCC_B_LOAD_FILTER]) && !swRstWr
    |=> !q.cmd[NCC_B_LOAD_FILTER] && !engOut.loadFilterReq)
    else $error("filter load bit not cleared on completion");

  a_zero_write_keeps: assert property (opWr && q.cmd[NCC_B_FETCH_DESC]
    && !wbReq.dat[NCC_B_FETCH_DESC] && !engIn.fetchDone
    |=> q.cmd[NCC_B_FETCH_DESC])
    else $error("zero write cleared a command bit");

  a_reset_bit_sticks: assert property (q.cmd[NCC_B_SOFT_RESET]
    && !(wrCmd && wrMask[NCC_B_SOFT_RESET] && !wbReq.dat[NCC_B_SOFT_RESET])
    |=> q.cmd[NCC_B_SOFT_RESET])
    else $error("soft reset bit cleared itself");

  a_reset_blocks_cmds: assert property (q.cmd[NCC_B_SOFT_RESET] && wrCmd
    |=> q.cmd[NCC_B_SEND_FRAMES] == $past(q.cmd[NCC_B_SEND_FRAMES])
        && q.cmd[NCC_B_LOAD_FILTER] == $past(q.cmd[NCC_B_LOAD_FILTER]))
    else $error("command taken while in soft reset");

  a_soft_reset_value: assert property (swRstWr
    |=> q.cmd[9:8] == 2'b00 && q.cmd[1:0] == 2'b00 && q.cmd[7] && q.cmd[2]
        && q.cmd[5:3] == $past(q.cmd[5:3]))
    else $error("wrong soft reset value");

  a_held_in_reset: assert property (q.cmd[NCC_B_SOFT_RESET]
    |-> engOut.engineReset && !engOut.crcEnable && !engOut.tallyRun
        && !engOut.sendActive && !engOut.timerRun)
    else $error("engines active during soft reset");

  a_both_timer_stop: assert property (opWr && wrSet[NCC_B_TIMER_RUN] && wrSet[NCC_B_TIMER_HALT]
    |=> q.cmd[NCC_B_TIMER_HALT] && !q.cmd[NCC_B_TIMER_RUN] ##1 !engOut.timerRun)
    else $error("run with halt did not stop timer");

  a_run_clears_halt: assert property (opWr && wrSet[NCC_B_TIMER_RUN] && !wrSet[NCC_B_TIMER_HALT]
    |=> q.cmd[NCC_B_TIMER_RUN] && !q.cmd[NCC_B_TIMER_HALT] && engOut.timerRun)
    else $error("run did not clear halt");

  a_eol_ends_send: assert property (running && q.txState == NCC_TX_RUN && engIn.eolSeen
    && !(opWr && wrSet[NCC_B_SEND_FRAMES])
    |=> !q.cmd[NCC_B_SEND_FRAMES] && q.txState == NCC_TX_IDLE)
    else $error("send not cleared at end of list");

  a_halt_waits_frame: assert property (running && q.txState == NCC_TX_HALT && !engIn.frameDone
    && !engIn.eolSeen && !engIn.txAbort && !swRstWr
    |=> q.cmd[NCC_B_SEND_FRAMES])
    else $error("send dropped before frame finished");

  a_rx_busy_holds: assert property (running && q.cmd[NCC_B_RECEIVE_ON]
    && q.cmd[NCC_B_RECEIVE_OFF] && engIn.rxFrameBusy && !wrCmd
    |=> q.cmd[NCC_B_RECEIVE_ON] && q.cmd[NCC_B_RECEIVE_OFF] && !engOut.rxBuffering)
    else $error("receive bits resolved mid frame");

  a_rx_off_at_idle: assert property (running && q.cmd[NCC_B_RECEIVE_ON]
    && q.cmd[NCC_B_RECEIVE_OFF] && !q.rxLastOn && !engIn.rxFrameBusy && !wrCmd
    |=> !q.cmd[NCC_B_RECEIVE_ON] && q.cmd[NCC_B_RECEIVE_OFF])
    else $error("receive on not cleared after disable");

  a_read_live_value: assert property (wbReq.cyc && wbReq.stb && !wbReq.we
    && wbReq.adr == NCC_CMD_OFS && !wbRsp.ack
    |=> wbRsp.ack && wbRsp.dat == {16'h0000, $past(q.cmd)})
    else $error("command read returned stale data");

  // Register value seen at the first edge after hardware reset is released
  a_hw_reset_value: assert property ($rose(arst_n) |-> q.cmd == NCC_CMD_HW_RESET)
    else $error("wrong hardware reset value");

  a_fetch_done_clears: assert property (running && q.cmd[NCC_B_FETCH_DESC]
    && engIn.fetchDone && !(opWr && wrSet[NCC_B_FETCH_DESC]) && !swRstWr
    |=> !q.cmd[NCC_B_FETCH_DESC] && !engOut.fetchDescReq)
    else $error("fetch bit not cleared on completion");

  a_halt_clears_run: assert property (opWr && wrSet[NCC_B_TIMER_HALT]
    |=> q.cmd[NCC_B_TIMER_HALT] && !q.cmd[NCC_B_TIMER_RUN] && !engOut.timerRun)
    else $error("halt did not clear run");

  a_abort_ends_send: assert property (running && q.txState == NCC_TX_RUN && engIn.txAbort
    && !(opWr && wrSet[NCC_B_SEND_FRAMES])
    |=> !q.cmd[NCC_B_SEND_FRAMES] && q.txState == NCC_TX_IDLE)
    else $error("send not cleared on abort");

  a_halt_ends_send: assert property (running && q.txState == NCC_TX_HALT
    && engIn.frameDone && !opWr
    |=> !q.cmd[NCC_B_SEND_FRAMES] && !q.cmd[NCC_B_STOP_SENDING])
    else $error("send kept after halted frame");

  a_rx_on_at_idle: assert property (running && q.cmd[NCC_B_RECEIVE_ON]
    && q.cmd[NCC_B_RECEIVE_OFF] && q.rxLastOn && !engIn.rxFrameBusy && !wrCmd
    |=> q.cmd[NCC_B_RECEIVE_ON] && !q.cmd[NCC_B_RECEIVE_OFF])
    else $error("receive off not cleared after enable");

  // Engine requests must mirror the register, never lag it
  a_req_follows_bits: assert property (engOut.loadFilterReq
    == (q.cmd[NCC_B_LOAD_FILTER] && !q.cmd[NCC_B_SOFT_RESET]) && engOut.fetchDescReq
    == (q.cmd[NCC_B_FETCH_DESC] && !q.cmd[NCC_B_SOFT_RESET]))
    else $error("engine request out of step");

  a_timer_run_level: assert property (engOut.timerRun
    == (q.cmd[NCC_B_TIMER_RUN] && !q.cmd[NCC_B_SOFT_RESET]))
    else $error("timer run out of step");

  a_zero_keeps_send: assert property (opWr && q.cmd[NCC_B_SEND_FRAMES]
    && !wbReq.dat[NCC_B_SEND_FRAMES] && q.txState == NCC_TX_IDLE
    |=> q.cmd[NCC_B_SEND_FRAMES])
    else $error("zero write cleared send");

  a_reset_idles_tx: assert property (q.cmd[NCC_B_SOFT_RESET] |-> q.txState == NCC_TX_IDLE)
    else $error("transmit state active in soft reset");

  a_lone_stop_clears: assert property (running && q.txState == NCC_TX_IDLE
    && !q.cmd[NCC_B_SEND_FRAMES] && q.cmd[NCC_B_STOP_SENDING] && !opWr
    |=> !q.cmd[NCC_B_STOP_SENDING])
    else $error("stop sending stuck with nothing to halt");

  c_reset_release: cover property (q.cmd[NCC_B_SOFT_RESET] ##1 !q.cmd[NCC_B_SOFT_RESET]);
  c_halt_path: cover property (q.txState == NCC_TX_HALT ##[1:20] q.txState == NCC_TX_IDLE);
  c_rx_both_set: cover property (q.cmd[NCC_B_RECEIVE_ON] && q.cmd[NCC_B_RECEIVE_OFF]
    && engIn.rxFrameBusy);
  c_filter_load: cover property (engOut.loadFilterReq ##[1:50] !engOut.loadFilterReq);

endmodule : ncc_command_reg

/* verification/ncc_testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ncc_pkg::*;

  // One table row: a command write and the register value that should follow it
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] exp;
  } ncc_row_t;

  logic coreClk;
  logic arstN;
  ncc_wb_req_t wbReq;
  ncc_wb_rsp_t wbRsp;
  ncc_eng_in_t engIn;
  ncc_eng_out_t engOut;
  logic timerLoad;
  logic [31:0] timerLoadValue;
  logic timerIrqEnable;
  logic [31:0] timerCount;
  logic timerIrq;
  logic [31:0] rdat;
  logic [31:0] cnt;
  int nFail;
  int nTests;
  int n;

  // Ordinary command writes, engines quiet, starting from 0x0014
  ncc_row_t rows [7] = '{
    '{16'h0000, 16'h0014},
    '{16'h0020, 16'h0024},
    '{16'h0030, 16'h0014},
    '{16'h0008, 16'h0018},
    '{16'h0004, 16'h0014},
    '{16'h0200, 16'h0214},
    '{16'h0100, 16'h0314}
  };

  ncc_command_reg DUT (
    .core_clk(coreClk),
    .arst_n(arstN),
    .wbReq(wbReq),
    .wbRsp(wbRsp),
    .engIn(engIn),
    .engOut(engOut),
    .timerLoad(timerLoad),
    .timerLoadValue(timerLoadValue),
    .timerIrqEnable(timerIrqEnable),
    .timerCount(timerCount),
    .timerIrq(timerIrq)
  );

  // 25 MHz core clock
  initial begin
    coreClk = 1'b0;
    forever #20 coreClk = ~coreClk;
  end

  task automatic tally_and_finish;
    if (nFail == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle; entered just after a rising edge, leaves after a full idle cycle
  task automatic wb_access(input logic we, input logic [3:0] adr, input logic [15:0] wd,
                           output logic [31:0] rd);
    int k;
    k = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: {16'h0000, wd}, sel: 4'hf};
    // Read right after the edge, ack and data still hold what that edge sampled
    do begin
      @(posedge coreClk);
      k++;
    end while (wbRsp.ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    rd = wbRsp.dat;
    wbReq <= '0;
    @(posedge coreClk);
  endtask : wb_access

  task automatic rd_cmd(input logic [15:0] exp);
    wb_access(1'b0, NCC_CMD_OFS, 16'h0000, rdat);
    chk(rdat, {16'h0000, exp});
  endtask : rd_cmd

  task automatic wr_cmd(input logic [15:0] val);
    wb_access(1'b1, NCC_CMD_OFS, val, rdat);
  endtask : wr_cmd

  // Single-cycle pulse on the chosen engine status lines
  task automatic pulse(input ncc_eng_in_t m);
    engIn <= engIn | m;
    @(posedge coreClk);
    engIn <= engIn & ~m;
    @(posedge coreClk);
  endtask : pulse

  task automatic check_reset;
    rd_cmd(16'h0094);
    chk(engOut.engineReset, 1'b1);
    chk(engOut.timerRun, 1'b0);
  endtask : check_reset

  // Hang guard, well above the few hundred cycles the sequence needs
  initial begin
    #400000;
    nFail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    arstN = 1'b0;
    wbReq = '0;
    engIn = '0;
    timerLoad = 1'b0;
    timerLoadValue = '0;
    timerIrqEnable = 1'b0;
    nFail = 0;
    nTests = 0;
    repeat (20) @(posedge coreClk);
    arstN <= 1'b1;
    @(posedge coreClk);
    check_reset();
    // Commands issued while reset is held are dropped
    wr_cmd(16'h0282);
    rd_cmd(16'h0094);
    wr_cmd(16'h0000);
    rd_cmd(16'h0014);
    chk(engOut.engineReset, 1'b0);
    // Table writes, then filter load and descriptor fetch cleared by their done pulses
    for (int i = 0; i < 7; i++) begin
      wr_cmd(rows[i].wr);
      rd_cmd(rows[i].exp);
    end
    chk(engOut.loadFilterReq, 1'b1);
    chk(engOut.fetchDescReq, 1'b1);
    pulse(6'h20);
    rd_cmd(16'h0114);
    pulse(6'h10);
    rd_cmd(16'h0014);
    // Loaded timer must hold until run is set
    timerIrqEnable <= 1'b1;
    timerLoadValue <= 32'h0000_0005;
    timerLoad <= 1'b1;
    @(posedge coreClk);
    timerLoad <= 1'b0;
    repeat (4) @(posedge coreClk);
    @(negedge coreClk);
    chk(timerCount, 32'h0000_0005);
    @(posedge coreClk);
    wr_cmd(16'h0020);
    n = 0;
    do begin
      @(negedge coreClk);
      n++;
    end while (timerIrq !== 1'b1 && n < 40);
    chk(n < 40, 1'b1);
    chk(timerCount, 32'h0);
    @(posedge coreClk);
    wr_cmd(16'h0010);
    @(negedge coreClk);
    cnt = timerCount;
    repeat (3) @(negedge coreClk);
    chk(timerCount, cnt);
    @(posedge coreClk);
    rd_cmd(16'h0014);
    // Send ends on end of list, on abort, and on halt after the frame
    wr_cmd(16'h0002);
    rd_cmd(16'h0016);
    chk(engOut.sendActive, 1'b1);
    pulse(6'h08);
    rd_cmd(16'h0014);
    wr_cmd(16'h0002);
    pulse(6'h04);
    rd_cmd(16'h0014);
    wr_cmd(16'h0002);
    wr_cmd(16'h0001);
    rd_cmd(16'h0017);
    chk(engOut.haltReq, 1'b1);
    pulse(6'h02);
    rd_cmd(16'h0014);
    // Receive on during a busy frame keeps both bits until the line idles
    engIn.rxFrameBusy <= 1'b1;
    wr_cmd(16'h0008);
    rd_cmd(16'h001c);
    engIn.rxFrameBusy <= 1'b0;
    repeat (2) @(posedge coreClk);
    rd_cmd(16'h0018);
    chk(engOut.rxBuffering, 1'b1);
    // Soft reset keeps timer and receive on bits, sets receive off, drops fetch and send
    wr_cmd(16'h0102);
    wr_cmd(16'h0080);
    rd_cmd(16'h009c);
    chk(engOut.engineReset, 1'b1);
    chk(engOut.crcEnable, 1'b0);
    chk(engOut.tallyRun, 1'b0);
    chk(engOut.sendActive, 1'b0);
    // Unmapped place reads zero
    wb_access(1'b0, 4'h8, 16'h0000, rdat);
    chk(rdat, 32'h0);
    // Hardware reset in mid-run
    arstN <= 1'b0;
    repeat (3) @(posedge coreClk);
    arstN <= 1'b1;
    @(posedge coreClk);
    check_reset();
    tally_and_finish();
  end

endmodule : testbench
